// ==== rtl/ewps_pkg.sv ====
// Constants and state types for the EEPROM write-protect and status block.
// Assumes a 50 MHz system clock that oversamples the serial pins.
package ewps_pkg;
  // Command opcodes, sent MSB first
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  // Bit counts for frame ends, the last address bit, the wrap points and saturation
  localparam logic [5:0] CNT_OPC = 6'h08;
  localparam logic [5:0] CNT_STATUS = 6'h10;
  localparam logic [5:0] CNT_ADDR_END = 6'h17;
  localparam logic [5:0] CNT_WRITE = 6'h20;
  localparam logic [5:0] CNT_WRITE_WRAP = 6'h27;
  localparam logic [5:0] CNT_READ_WRAP = 6'h0F;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  // Status byte layout
  localparam int SB_PIN_EN = 7;
  localparam int SB_GUARD_HI = 3;
  localparam int SB_GUARD_LO = 2;
  localparam int SB_LATCH = 1;
  localparam int SB_BUSY = 0;
  // Guarded ranges
  localparam logic [10:0] QUARTER_BASE = 11'h600;
  localparam logic [10:0] HALF_BASE = 11'h400;
  // Reset values (nonvolatile bits start cleared in this model)
  localparam logic RST_PIN_EN = 1'b0;
  localparam logic [1:0] RST_GUARD = 2'h0;
  localparam logic RST_LATCH = 1'b0;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
    logic rise;
    logic fall;
  } ewps_sync_t;

  typedef struct packed {
    logic sel;
    logic [5:0] cnt;
    logic [7:0] sh;
    logic [7:0] op;
    logic [10:0] addr;
    logic latch;
    logic busy;
    logic pin_en;
    logic [1:0] guard;
    logic so;
    logic so_oe;
    logic wr_start;
    logic [10:0] wr_addr;
    logic commit;
  } ewps_st_t;
endpackage : ewps_pkg

// ==== rtl/ewps_sync.sv ====
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the pin is slow against clk_i.
`timescale 1ns/10ps
`default_nettype none
module ewps_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pin and filtered result
  input wire logic pin_i,
  output logic lvl_o,
  output logic rise_o,
  output logic fall_o
);
  ewps_pkg::ewps_sync_t s_r;
  ewps_pkg::ewps_sync_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = pin_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // Only a level seen by both later stages is taken
    if (s_r.s2 == s_r.s3)
    begin
      s_nxt.f = s_r.s3;
    end
    s_nxt.rise = s_nxt.f & ~s_r.f;
    s_nxt.fall = ~s_nxt.f & s_r.f;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_r <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL, 1'b0, 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign lvl_o = s_r.f;
  assign rise_o = s_r.rise;
  assign fall_o = s_r.fall;
endmodule : ewps_sync
`default_nettype wire

// ==== rtl/ewps_guard.sv ====
// Protection matrix: block guard decode plus the hardware protect pin.
// Purely combinational; the caller registers the decisions it acts on.
`timescale 1ns/10ps
`default_nettype none
module ewps_guard (
  // Protection state
  input wire logic latch_i,
  input wire logic pin_en_i,
  input wire logic wp_n_i,
  input wire logic [1:0] guard_i,
  input wire logic [10:0] addr_i,
  // Decisions
  output logic hw_prot_o,
  output logic array_ok_o,
  output logic status_ok_o
);
  logic blocked;

  always_comb
  begin
    unique case (guard_i)
      2'h0: blocked = 1'b0;
      2'h1: blocked = (addr_i >= ewps_pkg::QUARTER_BASE);
      2'h2: blocked = (addr_i >= ewps_pkg::HALF_BASE);
      2'h3: blocked = 1'b1;
    endcase
  end

  assign hw_prot_o = pin_en_i & ~wp_n_i;
  assign array_ok_o = latch_i & ~blocked;
  assign status_ok_o = latch_i & ~hw_prot_o;
endmodule : ewps_guard
`default_nettype wire

// ==== rtl/ewps_core.sv ====
// Write-protect, write enable latch and status byte of a serial EEPROM.
// Assumes an array datapath outside that programs the page after
// array_wr_start_o and pulses write_done_i when its cycle ends.
//
// Overview of operation
// - Enable sets latch, disable clears it
// - Latch clears at reset, disable, completed writes
// - Status read works anytime, even while busy
// - Status byte: pin enable, guards, latch, busy
// - Busy flag shows write cycle, read-only
// - Latch flag mirrors latch, read-only
// - Enable/disable ignore status protection state
// - Guard bits change only on accepted write
// - Guard code selects none, quarter, half, all
// - Pin enable bit written by status write
// - Hardware protection when pin low, enable set
// - Hardware protection refuses status writes only
// - Guarded blocks never written; latch gates writes
// - Write cycle starts only on exact deselect
// - Array access ignored during write cycle
// - Power-up standby, output released, latch clear
// - Opcodes 06, 04, 05, 01, MSB first
// - Latch set only on deselect after eight bits
// - Protect pin cannot abort started write
`timescale 1ns/10ps
`default_nettype none
module ewps_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o,
  // Array datapath
  output logic array_wr_start_o,
  output logic [10:0] array_wr_addr_o,
  input wire logic write_done_i,
  // Nonvolatile store and state
  output logic nv_commit_o,
  output logic [7:0] status_o,
  output logic standby_o
);
  ewps_pkg::ewps_st_t s_r;
  ewps_pkg::ewps_st_t s_nxt;
  logic cs_lvl;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic si_lvl;
  logic wp_lvl;
  logic hw_prot;
  logic array_ok;
  logic status_ok;
  logic [7:0] status;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  ewps_sync #(.RST_VAL(1'b1)) u_cs (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(cs_n_i),
    .lvl_o(cs_lvl),
    .rise_o(cs_rise),
    .fall_o(cs_fall)
  );

  ewps_sync #(.RST_VAL(1'b0)) u_sck (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(sck_i),
    .lvl_o(),
    .rise_o(sck_rise),
    .fall_o(sck_fall)
  );

  ewps_sync #(.RST_VAL(1'b0)) u_si (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(si_i),
    .lvl_o(si_lvl),
    .rise_o(),
    .fall_o()
  );

  ewps_sync #(.RST_VAL(1'b1)) u_wp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(wp_n_i),
    .lvl_o(wp_lvl),
    .rise_o(),
    .fall_o()
  );

  //////////////////////////////////////////////////////////////////////
  // Protection decisions

  ewps_guard u_guard (
    .latch_i(s_r.latch),
    .pin_en_i(s_r.pin_en),
    .wp_n_i(wp_lvl),
    .guard_i(s_r.guard),
    .addr_i(s_r.addr),
    .hw_prot_o(hw_prot),
    .array_ok_o(array_ok),
    .status_ok_o(status_ok)
  );

  // Unused positions read zero
  always_comb
  begin
    status = 8'h00;
    status[ewps_pkg::SB_PIN_EN] = s_r.pin_en;
    status[ewps_pkg::SB_GUARD_HI] = s_r.guard[1];
    status[ewps_pkg::SB_GUARD_LO] = s_r.guard[0];
    status[ewps_pkg::SB_LATCH] = s_r.latch;
    status[ewps_pkg::SB_BUSY] = s_r.busy;
  end

  //////////////////////////////////////////////////////////////////////
  // Bit counter; status reads and page writes wrap so long frames stay legal

  function automatic logic [5:0] next_cnt(input logic [7:0] op, input logic [5:0] cnt);
    logic [5:0] r;
    r = cnt + 6'h01;
    if (cnt == ewps_pkg::CNT_MAX)
    begin
      r = cnt;
    end
    else if (op == ewps_pkg::OP_ARRAY_WRITE && cnt == ewps_pkg::CNT_WRITE_WRAP)
    begin
      r = ewps_pkg::CNT_WRITE;
    end
    else if (op == ewps_pkg::OP_STATUS_READ && cnt == ewps_pkg::CNT_READ_WRAP)
    begin
      r = ewps_pkg::CNT_OPC;
    end
    return r;
  endfunction : next_cnt

  //////////////////////////////////////////////////////////////////////
  // Command handling

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.wr_start = 1'b0;
    s_nxt.commit = 1'b0;
    // Completion of the internal cycle ends busy and drops the latch
    if (s_r.busy && write_done_i)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.latch = 1'b0;
    end
    if (cs_fall)
    begin
      s_nxt.sel = 1'b1;
      s_nxt.cnt = 6'h00;
      s_nxt.op = 8'h00;
    end
    if (s_r.sel && sck_rise)
    begin
      s_nxt.sh = {s_r.sh[6:0], si_lvl};
      s_nxt.cnt = next_cnt(s_r.op, s_r.cnt);
      if (s_r.cnt == ewps_pkg::CNT_OPC - 6'h01)
      begin
        s_nxt.op = {s_r.sh[6:0], si_lvl};
      end
      if (s_r.cnt >= ewps_pkg::CNT_OPC && s_r.cnt <= ewps_pkg::CNT_ADDR_END)
      begin
        s_nxt.addr = {s_r.addr[9:0], si_lvl};
      end
    end
    // Status shifts out after each falling edge, busy or not
    if (s_r.sel && sck_fall && s_r.op == ewps_pkg::OP_STATUS_READ &&
        s_r.cnt >= ewps_pkg::CNT_OPC)
    begin
      s_nxt.so_oe = 1'b1;
      s_nxt.so = status[~s_r.cnt[2:0]];
    end
    if (s_r.sel && cs_rise)
    begin
      s_nxt.sel = 1'b0;
      s_nxt.so_oe = 1'b0;
      // Commands act only on a deselect after a whole frame
      if (!s_r.busy)
      begin
        if (s_r.op == ewps_pkg::OP_LATCH_SET && s_r.cnt == ewps_pkg::CNT_OPC)
        begin
          s_nxt.latch = 1'b1;
        end
        if (s_r.op == ewps_pkg::OP_LATCH_CLEAR && s_r.cnt == ewps_pkg::CNT_OPC)
        begin
          s_nxt.latch = 1'b0;
        end
        if (s_r.op == ewps_pkg::OP_STATUS_WRITE && s_r.cnt == ewps_pkg::CNT_STATUS &&
            status_ok)
        begin
          s_nxt.pin_en = s_r.sh[ewps_pkg::SB_PIN_EN];
          s_nxt.guard = s_r.sh[ewps_pkg::SB_GUARD_HI:ewps_pkg::SB_GUARD_LO];
          s_nxt.busy = 1'b1;
          s_nxt.commit = 1'b1;
        end
        // Protection is judged once here; later pin changes cannot abort
        if (s_r.op == ewps_pkg::OP_ARRAY_WRITE && s_r.cnt == ewps_pkg::CNT_WRITE &&
            array_ok)
        begin
          s_nxt.busy = 1'b1;
          s_nxt.wr_start = 1'b1;
          s_nxt.wr_addr = s_r.addr;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_r.sel <= 1'b0;
      s_r.cnt <= 6'h00;
      s_r.sh <= 8'h00;
      s_r.op <= 8'h00;
      s_r.addr <= 11'h000;
      s_r.latch <= ewps_pkg::RST_LATCH;
      s_r.busy <= 1'b0;
      s_r.pin_en <= ewps_pkg::RST_PIN_EN;
      s_r.guard <= ewps_pkg::RST_GUARD;
      s_r.so <= 1'b0;
      s_r.so_oe <= 1'b0;
      s_r.wr_start <= 1'b0;
      s_r.wr_addr <= 11'h000;
      s_r.commit <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign so_o = s_r.so;
  assign so_oe_o = s_r.so_oe;
  assign array_wr_start_o = s_r.wr_start;
  assign array_wr_addr_o = s_r.wr_addr;
  assign nv_commit_o = s_r.commit;
  assign status_o = status;
  assign standby_o = ~s_r.sel;

  //////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_busy_start;
    $rose(s_r.busy) |-> $past(cs_rise) && $past(s_r.sel);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without deselect");

  property p_done_clears;
    s_r.busy && write_done_i |=> !s_r.latch && !s_r.busy;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("latch kept after done");

  property p_status_fmt;
    status_o[6:4] == 3'h0 && status_o[1] == s_r.latch && status_o[0] == s_r.busy;
  endproperty
  a_status_fmt: assert property (p_status_fmt) else $error("status byte layout wrong");

  property p_hw_refuse;
    nv_commit_o |-> $past(s_r.latch) && !($past(s_r.pin_en) && !$past(wp_lvl));
  endproperty
  a_hw_refuse: assert property (p_hw_refuse) else $error("status write while protected");

  property p_guard_hold;
    $changed(s_r.guard) || $changed(s_r.pin_en) |-> nv_commit_o;
  endproperty
  a_guard_hold: assert property (p_guard_hold) else $error("guard changed without write");

  property p_array_guard;
    array_wr_start_o |-> $past(s_r.latch) && !(s_r.guard == 2'h3) &&
      !(s_r.guard == 2'h2 && array_wr_addr_o >= 11'h400) &&
      !(s_r.guard == 2'h1 && array_wr_addr_o >= 11'h600);
  endproperty
  a_array_guard: assert property (p_array_guard) else $error("guarded block written");

  property p_busy_block;
    s_r.busy |=> !array_wr_start_o && !nv_commit_o;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("access during write cycle");

  property p_latch_set;
    cs_rise && s_r.sel && !s_r.busy && s_r.op == 8'h06 && s_r.cnt == 6'h08 |=> s_r.latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("enable did not set latch");

  property p_so_release;
    cs_lvl && $past(cs_lvl) |-> !so_oe_o;
  endproperty
  a_so_release: assert property (p_so_release) else $error("output driven in standby");

  property p_rd_drive;
    s_r.sel && sck_fall && !cs_rise && s_r.op == 8'h05 && s_r.cnt >= 6'h08 |=> so_oe_o;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("status read not driven");

  property p_latch_clear;
    cs_rise && s_r.sel && !s_r.busy && s_r.op == 8'h04 && s_r.cnt == 6'h08 |=> !s_r.latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("disable did not clear latch");

  property p_busy_hold;
    s_r.busy && !write_done_i |=> s_r.busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("write cycle aborted");

  property p_latch_kept;
    nv_commit_o |-> s_r.latch;
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("status write changed latch");

  property p_len_refuse;
    cs_rise && s_r.sel && s_r.op == 8'h06 && s_r.cnt != 6'h08 && !s_r.latch |=> !s_r.latch;
  endproperty
  a_len_refuse: assert property (p_len_refuse) else $error("latch set by long frame");

  property p_rd_msb;
    s_r.sel && sck_fall && !cs_rise && s_r.op == 8'h05 && s_r.cnt >= 6'h08 &&
      s_r.cnt[2:0] == 3'h0 |=> so_o == $past(status_o[7]);
  endproperty
  a_rd_msb: assert property (p_rd_msb) else $error("status read not MSB first");

  c_latch_set: cover property ($rose(s_r.latch));
  c_array_wr: cover property (array_wr_start_o);
  c_status_wr: cover property (nv_commit_o);
  c_hw_refused: cover property (cs_rise && s_r.op == 8'h01 && s_r.latch && hw_prot);
  c_rd_busy: cover property (so_oe_o && s_r.busy);
endmodule : ewps_core
`default_nettype wire

// ==== test/ewps_host.sv ====
// SPI bus master model that frames whole bytes for the status block.
// Assumes clk_i is the device clock; pins move on its falling edge.
`timescale 1ns/10ps
`default_nettype none
module ewps_host (
  // Clock
  input wire logic clk_i,
  // Serial pins
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  // Phases longer than the device's four-cycle pin filter
  localparam int HALF = 6;

  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_clk

  task automatic sel();
    wait_clk(1);
    cs_n_o = 1'b0;
    wait_clk(HALF);
  endtask : sel

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck_o = 1'b0;
      si_o = tx[i];
      wait_clk(HALF);
      rx[i] = so_i;
      sck_o = 1'b1;
      wait_clk(HALF);
    end
  endtask : xfer

  // Deselect only after whole bytes, so the frame length is exact
  task automatic desel();
    sck_o = 1'b0;
    wait_clk(HALF);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    wait_clk(8);
  endtask : desel
endmodule : ewps_host
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the write-protect and status block.
// Assumes the host model drives the serial pins on falling clk edges.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i;
  logic rstn_i;
  logic wp_n_i;
  logic write_done_i;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic start;
  logic commit;
  logic standby;
  logic [10:0] wr_addr;
  logic [7:0] status;
  logic [7:0] rd;
  int mismatches;
  int n_compared;
  int n_start;
  int n_commit;

  ewps_core u_ewps_core (
    .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .array_wr_start_o(start),
    .array_wr_addr_o(wr_addr), .write_done_i(write_done_i), .nv_commit_o(commit),
    .status_o(status), .standby_o(standby)
  );
  ewps_host u_ewps_host (
    .clk_i(clk_i), .so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    if (start === 1'b1)
      n_start++;
    if (commit === 1'b1)
      n_commit++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chkv(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chkv

  task automatic chkn(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      mismatches++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  task automatic cmd(input logic [7:0] op);
    u_ewps_host.sel();
    u_ewps_host.xfer(op, rd);
    u_ewps_host.desel();
  endtask : cmd

  task automatic status_write_cmd(input logic [7:0] d);
    u_ewps_host.sel();
    u_ewps_host.xfer(ewps_pkg::OP_STATUS_WRITE, rd);
    u_ewps_host.xfer(d, rd);
    u_ewps_host.desel();
  endtask : status_write_cmd

  task automatic status_read_cmd();
    u_ewps_host.sel();
    u_ewps_host.xfer(ewps_pkg::OP_STATUS_READ, rd);
    u_ewps_host.xfer(8'hFF, rd);
    chkv({10'h000, so_oe}, 11'h001);
    u_ewps_host.desel();
  endtask : status_read_cmd

  task automatic awrite(input logic [10:0] a);
    u_ewps_host.sel();
    u_ewps_host.xfer(ewps_pkg::OP_ARRAY_WRITE, rd);
    u_ewps_host.xfer({5'h00, a[10:8]}, rd);
    u_ewps_host.xfer(a[7:0], rd);
    u_ewps_host.xfer(8'hA5, rd);
    u_ewps_host.desel();
  endtask : awrite

  // Stands in for the array datapath ending its cycle
  task automatic done();
    u_ewps_host.wait_clk(3);
    write_done_i = 1'b1;
    u_ewps_host.wait_clk(1);
    write_done_i = 1'b0;
    u_ewps_host.wait_clk(2);
  endtask : done

  task automatic chks(input logic [7:0] exp);
    chkv({3'h0, status}, {3'h0, exp});
  endtask : chks

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_latch();
    cmd(ewps_pkg::OP_LATCH_SET);
    chks(8'h02);
    status_read_cmd();
    chkv({3'h0, rd}, 11'h002);
    chkv({10'h000, so_oe}, 11'h000);
    cmd(ewps_pkg::OP_LATCH_CLEAR);
    chks(8'h00);
    u_ewps_host.sel();
    chkv({10'h000, standby}, 11'h000);
    u_ewps_host.xfer(ewps_pkg::OP_LATCH_SET, rd);
    u_ewps_host.xfer(ewps_pkg::OP_STATUS_READ, rd);
    u_ewps_host.desel();
    chks(8'h00);
  endtask : t_latch

  task automatic t_status();
    cmd(ewps_pkg::OP_LATCH_SET);
    status_write_cmd(8'hF0);
    chks(8'h83);
    status_read_cmd();
    chkv({3'h0, rd}, 11'h083);
    chkn(n_commit, 1);
    done();
    chks(8'h80);
    cmd(ewps_pkg::OP_LATCH_SET);
    cmd(ewps_pkg::OP_STATUS_WRITE);
    chks(8'h82);
  endtask : t_status

  task automatic t_hwprot();
    wp_n_i = 1'b0;
    status_write_cmd(8'h0C);
    chks(8'h82);
    chkn(n_commit, 1);
    cmd(ewps_pkg::OP_LATCH_CLEAR);
    chks(8'h80);
    cmd(ewps_pkg::OP_LATCH_SET);
    chks(8'h82);
    awrite(11'h123);
    chkn(n_start, 1);
    done();
    chks(8'h80);
    wp_n_i = 1'b1;
    cmd(ewps_pkg::OP_LATCH_SET);
    status_write_cmd(8'h84);
    chks(8'h87);
    wp_n_i = 1'b0;
    done();
    chks(8'h84);
    wp_n_i = 1'b1;
    cmd(ewps_pkg::OP_LATCH_SET);
    status_write_cmd(8'h00);
    done();
    chks(8'h00);
  endtask : t_hwprot

  task automatic t_guard();
    int n0;
    logic [11:0] lim [4];
    logic [10:0] adr [4];
    lim = '{12'h800, 12'h600, 12'h400, 12'h000};
    adr = '{11'h3FF, 11'h400, 11'h5FF, 11'h600};
    for (int g = 0; g < 4; g++)
    begin
      cmd(ewps_pkg::OP_LATCH_SET);
      status_write_cmd({4'h0, g[1:0], 2'h0});
      done();
      chks({4'h0, g[1:0], 2'h0});
      for (int k = 0; k < 4; k++)
      begin
        n0 = n_start;
        cmd(ewps_pkg::OP_LATCH_SET);
        awrite(adr[k]);
        if ({1'b0, adr[k]} < lim[g])
        begin
          chkn(n_start - n0, 1);
          chkv(wr_addr, adr[k]);
          done();
        end
        else
        begin
          chkn(n_start - n0, 0);
        end
      end
    end
    cmd(ewps_pkg::OP_LATCH_SET);
    status_write_cmd(8'h00);
    done();
  endtask : t_guard

  task automatic t_busy();
    int n0;
    n0 = n_start;
    cmd(ewps_pkg::OP_LATCH_CLEAR);
    awrite(11'h010);
    chkn(n_start - n0, 0);
    cmd(ewps_pkg::OP_LATCH_SET);
    awrite(11'h020);
    awrite(11'h030);
    chkn(n_start - n0, 1);
    chkv(wr_addr, 11'h020);
    done();
    chks(8'h00);
    // Frame cut after the address must not start a cycle
    cmd(ewps_pkg::OP_LATCH_SET);
    u_ewps_host.sel();
    u_ewps_host.xfer(ewps_pkg::OP_ARRAY_WRITE, rd);
    u_ewps_host.xfer(8'h00, rd);
    u_ewps_host.xfer(8'h40, rd);
    u_ewps_host.desel();
    chkn(n_start - n0, 1);
    // Two data bytes exercise the page wrap of the bit counter
    u_ewps_host.sel();
    u_ewps_host.xfer(ewps_pkg::OP_ARRAY_WRITE, rd);
    u_ewps_host.xfer(8'h00, rd);
    u_ewps_host.xfer(8'h40, rd);
    u_ewps_host.xfer(8'hA5, rd);
    u_ewps_host.xfer(8'h5A, rd);
    u_ewps_host.desel();
    chkn(n_start - n0, 2);
    chkv(wr_addr, 11'h040);
    done();
    chks(8'h00);
  endtask : t_busy

  task automatic t_reset();
    cmd(ewps_pkg::OP_LATCH_SET);
    chks(8'h02);
    rstn_i = 1'b0;
    u_ewps_host.wait_clk(8);
    rstn_i = 1'b1;
    u_ewps_host.wait_clk(6);
    chks(8'h00);
    chkv({10'h000, standby}, 11'h001);
    cmd(ewps_pkg::OP_LATCH_SET);
    chks(8'h02);
  endtask : t_reset

  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Whole run is about 16k cycles; over four times that means a hang
  initial
  begin
    #1500000;
    mismatches++;
    summarize();
  end

  initial
  begin
    rstn_i = 1'b0;
    wp_n_i = 1'b1;
    write_done_i = 1'b0;
    mismatches = 0;
    n_compared = 0;
    n_start = 0;
    n_commit = 0;
    u_ewps_host.wait_clk(8);
    rstn_i = 1'b1;
    u_ewps_host.wait_clk(6);
    chks(8'h00);
    chkv({10'h000, so_oe}, 11'h000);
    chkv({10'h000, standby}, 11'h001);
    t_latch();
    t_status();
    t_hwprot();
    t_guard();
    t_busy();
    t_reset();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
